// [hw/cwf_top.sv]
// Purpose: capacity tracking and warning flags behind an apb slave
// Assumes: sense samples are synchronous adc codes
// Notes: pready comes one cycle into the access phase
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "cwf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cwf_top import cwf_pkg::*; (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // current sense samples
  input wire logic SENSE_SAMPLE_VALID,
  input wire logic signed [15:0] SENSE_INPUT_POS,
  input wire logic signed [15:0] SENSE_INPUT_NEG,
  // warnings and interrupt
  output logic CAPACITY_INITIAL_WARNING_FLAG,
  output logic CAPACITY_FINAL_WARNING_FLAG,
  output logic IRQ
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q;
  cwf_cap_t full_q, loadloss_q, unc_rem_q, unc_full_q;
  cwf_thr_t init_set_q, init_clr_q, final_set_q, final_clr_q;
  logic [31:0] cal_q, cpm_q;
  cwf_ev_t stat_q, stat_d, mask_q;
  logic [31:0] prdata_q, rdata;
  logic pready_q, pslverr_q, irq_q;
  logic init_q, final_q;
  logic signed [16:0] current;
  logic setup, done, wr, mapped, rem_load;

  cwf_if chan ();

  ////////////////////////////////////////////////////////////////////////
  // apb handshake
  // one wait state keeps read data and error in flops
  assign setup = PSEL && PENABLE && !pready_q;
  assign done = PSEL && PENABLE && pready_q;
  assign wr = done && PWRITE;
  assign rem_load = wr && PADDR == `CWF_OFF_REMAIN;

  always_comb begin
    mapped = 1'b1;
    rdata = 32'h0000_0000;
    unique case (PADDR)
      `CWF_OFF_CTRL: rdata = ctrl_q;
      `CWF_OFF_REMAIN: rdata = {16'h0000, chan.remaining};
      `CWF_OFF_FULL: rdata = {16'h0000, full_q};
      `CWF_OFF_LOADLOSS: rdata = {16'h0000, loadloss_q};
      `CWF_OFF_UNC_REM: rdata = {16'h0000, unc_rem_q};
      `CWF_OFF_UNC_FULL: rdata = {16'h0000, unc_full_q};
      `CWF_OFF_INIT_SET: rdata = {16'h0000, init_set_q};
      `CWF_OFF_INIT_CLR: rdata = {16'h0000, init_clr_q};
      `CWF_OFF_FINAL_SET: rdata = {16'h0000, final_set_q};
      `CWF_OFF_FINAL_CLR: rdata = {16'h0000, final_clr_q};
      `CWF_OFF_CAL: rdata = cal_q;
      `CWF_OFF_CPM: rdata = cpm_q;
      `CWF_OFF_FLAGS: rdata = {30'h0000_0000, final_q, init_q};
      `CWF_OFF_CURRENT: rdata = 32'(current);
      `CWF_OFF_INT_STAT: rdata = {28'h000_0000, stat_q};
      `CWF_OFF_INT_MASK: rdata = {28'h000_0000, mask_q};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      if (setup) begin
        prdata_q <= PWRITE ? 32'h0000_0000 : rdata;
        pslverr_q <= !mapped;
      end else begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control and capacity registers
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_q <= `CWF_CTRL_RST;
      full_q <= `CWF_FULL_RST;
      loadloss_q <= `CWF_LOADLOSS_RST;
      cal_q <= `CWF_CAL_RST;
      cpm_q <= `CWF_CPM_RST;
    end else if (wr) begin
      unique case (PADDR)
        `CWF_OFF_CTRL: ctrl_q <= {31'h0000_0000, PWDATA[`CWF_CTRL_EN_BIT]};
        `CWF_OFF_FULL: full_q <= PWDATA[15:0];
        `CWF_OFF_LOADLOSS: loadloss_q <= PWDATA[15:0];
        `CWF_OFF_CAL: cal_q <= PWDATA;
        `CWF_OFF_CPM: cpm_q <= PWDATA;
        default: ;
      endcase
    end
  end

  // thresholds kept in mAh, same unit as capacity
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      init_set_q <= `CWF_INIT_SET_RST;
      init_clr_q <= `CWF_INIT_CLR_RST;
      final_set_q <= `CWF_FINAL_SET_RST;
      final_clr_q <= `CWF_FINAL_CLR_RST;
    end else if (wr) begin
      unique case (PADDR)
        `CWF_OFF_INIT_SET: init_set_q <= PWDATA[15:0];
        `CWF_OFF_INIT_CLR: init_clr_q <= PWDATA[15:0];
        `CWF_OFF_FINAL_SET: final_set_q <= PWDATA[15:0];
        `CWF_OFF_FINAL_CLR: final_clr_q <= PWDATA[15:0];
        default: ;
      endcase
    end
  end

  assign chan.init_set = init_set_q;
  assign chan.init_clr = init_clr_q;
  assign chan.final_set = final_set_q;
  assign chan.final_clr = final_clr_q;

  ////////////////////////////////////////////////////////////////////////
  // load-uncompensated views, one cycle behind their inputs
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      unc_rem_q <= `CWF_REM_RST;
      unc_full_q <= `CWF_FULL_RST;
    end else begin
      unc_rem_q <= cwf_sat_add(chan.remaining, loadloss_q);
      unc_full_q <= cwf_sat_add(full_q, loadloss_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // charge integration and flags
  cwf_charge_acc u_acc (
    .clk(SYS_CLK),
    .rst(RESET),
    .sample_valid(SENSE_SAMPLE_VALID),
    .sense_input_pos(SENSE_INPUT_POS),
    .sense_input_neg(SENSE_INPUT_NEG),
    .enable(ctrl_q[`CWF_CTRL_EN_BIT]),
    .cal(cal_q),
    .counts_per_mah(cpm_q),
    .load(rem_load),
    .load_value(PWDATA[15:0]),
    .current_q(current),
    .bus(chan.acc)
  );

  cwf_warn_flags u_flags (
    .clk(SYS_CLK),
    .rst(RESET),
    .bus(chan.flags)
  );

  assign init_q = chan.init_flag;
  assign final_q = chan.final_flag;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status, write one to clear, a new event wins
  always_comb begin
    stat_d = stat_q;
    if (wr && PADDR == `CWF_OFF_INT_STAT) begin
      stat_d = stat_q & ~PWDATA[3:0];
    end
    stat_d = stat_d | chan.events;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      stat_q <= '0;
      mask_q <= `CWF_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      if (wr && PADDR == `CWF_OFF_INT_MASK) begin
        mask_q <= PWDATA[3:0];
      end
      irq_q <= |(stat_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // flag pins are the flag flops themselves, no extra delay
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CAPACITY_INITIAL_WARNING_FLAG = init_q;
  assign CAPACITY_FINAL_WARNING_FLAG = final_q;
  assign IRQ = irq_q;
endmodule
`default_nettype wire

// [hw/cwf_cfg.svh]
// Purpose: constants of the capacity warning block
// Assumes: byte addresses on a 32-bit apb bus
// Notes: values in the last group are reset defaults, except CWF_FINAL_OFF
`ifndef CWF_CFG_SVH
`define CWF_CFG_SVH
// register byte offsets
`define CWF_OFF_CTRL 8'h00
`define CWF_OFF_REMAIN 8'h04
`define CWF_OFF_FULL 8'h08
`define CWF_OFF_LOADLOSS 8'h0C
`define CWF_OFF_UNC_REM 8'h10
`define CWF_OFF_UNC_FULL 8'h14
`define CWF_OFF_INIT_SET 8'h18
`define CWF_OFF_INIT_CLR 8'h1C
`define CWF_OFF_FINAL_SET 8'h20
`define CWF_OFF_FINAL_CLR 8'h24
`define CWF_OFF_CAL 8'h28
`define CWF_OFF_CPM 8'h2C
`define CWF_OFF_FLAGS 8'h30
`define CWF_OFF_CURRENT 8'h34
`define CWF_OFF_INT_STAT 8'h38
`define CWF_OFF_INT_MASK 8'h3C
// field positions
`define CWF_CTRL_EN_BIT 0
`define CWF_FLAG_INIT_BIT 0
`define CWF_FLAG_FINAL_BIT 1
`define CWF_EV_INIT_SET 0
`define CWF_EV_INIT_CLR 1
`define CWF_EV_FINAL_SET 2
`define CWF_EV_FINAL_CLR 3
`define CWF_CAL_MANT_MSB 15
`define CWF_CAL_SHIFT_MSB 19
`define CWF_CAL_SHIFT_LSB 16
// reset values
`define CWF_CTRL_RST 32'h0000_0000
`define CWF_REM_RST 16'h0000
`define CWF_FULL_RST 16'h0000
`define CWF_LOADLOSS_RST 16'h0000
`define CWF_INIT_SET_RST 16'h0096
`define CWF_INIT_CLR_RST 16'h00AF
`define CWF_FINAL_SET_RST 16'h004B
`define CWF_FINAL_CLR_RST 16'h0064
`define CWF_FINAL_OFF 16'hFFFF
`define CWF_CAL_RST 32'h0000_0001
`define CWF_CPM_RST 32'h0000_0E10
`define CWF_MASK_RST 4'h0
`endif

// [hw/cwf_pkg.sv]
// Purpose: types and helpers of the capacity warning block
// Assumes: cwf_cfg.svh for field positions
// Notes: thresholds are signed, capacity unsigned, both in mAh
`include "cwf_cfg.svh"
package cwf_pkg;
  typedef logic [15:0] cwf_cap_t;
  typedef logic signed [15:0] cwf_thr_t;
  typedef logic [3:0] cwf_ev_t;

  // strict compare of capacity against a signed threshold
  function automatic logic cwf_below(cwf_cap_t cap, cwf_thr_t thr);
    return $signed({1'b0, cap}) < $signed({thr[15], thr});
  endfunction

  function automatic logic cwf_above(cwf_cap_t cap, cwf_thr_t thr);
    return $signed({1'b0, cap}) > $signed({thr[15], thr});
  endfunction

  // calibration word: own fixed format, mantissa and right shift
  function automatic logic signed [39:0] cwf_scale(
      logic signed [16:0] diff, logic [31:0] cal);
    logic signed [33:0] prod;
    prod = diff * $signed({1'b0, cal[`CWF_CAL_MANT_MSB:0]});
    return 40'(prod >>> cal[`CWF_CAL_SHIFT_MSB:`CWF_CAL_SHIFT_LSB]);
  endfunction

  // saturating capacity sum
  function automatic cwf_cap_t cwf_sat_add(cwf_cap_t a, cwf_cap_t b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction
endpackage

// [hw/cwf_if.sv]
// Purpose: capacity and flag channel between gauge parts
// Assumes: one clock domain
// Notes: remaining value and update strobe feed the flag logic
`timescale 1ns/1ps
`default_nettype none
interface cwf_if;
  import cwf_pkg::*;
  cwf_cap_t remaining;
  logic rem_upd;
  cwf_thr_t init_set, init_clr, final_set, final_clr;
  logic init_flag, final_flag;
  cwf_ev_t events;
  modport acc (output remaining, output rem_upd);
  modport flags (input remaining, input rem_upd, input init_set,
    input init_clr, input final_set, input final_clr,
    output init_flag, output final_flag, output events);
endinterface
`default_nettype wire

// [hw/cwf_charge_acc.sv]
// Purpose: integrate sensed charge into remaining capacity
// Assumes: sample strobe marks a new pos/neg pair
// Notes: at most one mAh step per sample
`include "cwf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cwf_charge_acc import cwf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sense samples
  input wire logic sample_valid,
  input wire logic signed [15:0] sense_input_pos,
  input wire logic signed [15:0] sense_input_neg,
  // control
  input wire logic enable,
  input wire logic [31:0] cal,
  input wire logic [31:0] counts_per_mah,
  input wire logic load,
  input wire cwf_cap_t load_value,
  output logic signed [16:0] current_q,
  // capacity channel
  cwf_if.acc bus
);
  cwf_cap_t rem_q, rem_d;
  logic signed [39:0] acc_q, acc_d, sum, cpm;
  logic upd_q, upd_d;
  logic signed [16:0] diff;

  assign diff = {sense_input_pos[15], sense_input_pos}
    - {sense_input_neg[15], sense_input_neg};
  assign cpm = $signed({8'h00, counts_per_mah});

  always_comb begin
    sum = acc_q + cwf_scale(diff, cal);
    rem_d = rem_q;
    acc_d = acc_q;
    upd_d = 1'b0;
    if (load) begin
      rem_d = load_value;
      acc_d = '0;
      upd_d = 1'b1;
    end else if (enable && sample_valid) begin
      // saturated capacity holds the residue instead of wrapping
      if (sum >= cpm) begin
        if (rem_q != 16'hFFFF) begin
          rem_d = rem_q + 16'h0001;
          acc_d = sum - cpm;
          upd_d = 1'b1;
        end
      end else if (sum <= -cpm) begin
        if (rem_q != 16'h0000) begin
          rem_d = rem_q - 16'h0001;
          acc_d = sum + cpm;
          upd_d = 1'b1;
        end
      end else begin
        acc_d = sum;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rem_q <= `CWF_REM_RST;
      acc_q <= '0;
      upd_q <= 1'b0;
    end else begin
      rem_q <= rem_d;
      acc_q <= acc_d;
      upd_q <= upd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      current_q <= '0;
    end else if (sample_valid) begin
      current_q <= diff;
    end
  end

  assign bus.remaining = rem_q;
  assign bus.rem_upd = upd_q;
endmodule
`default_nettype wire

// [hw/cwf_warn_flags.sv]
// Purpose: hysteretic low capacity warning flags
// Assumes: rem_upd pulses once per new remaining value
// Notes: threshold changes act only at the next update
`include "cwf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cwf_warn_flags import cwf_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // capacity channel
  cwf_if.flags bus
);
  logic init_q, final_q;
  cwf_ev_t ev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      init_q <= 1'b0;
    end else if (bus.rem_upd) begin
      if (!init_q && cwf_below(bus.remaining, bus.init_set)) begin
        init_q <= 1'b1;
      end else if (init_q && cwf_above(bus.remaining, bus.init_clr)) begin
        init_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      final_q <= 1'b0;
    end else if (bus.rem_upd) begin
      if (!final_q && bus.final_set != `CWF_FINAL_OFF &&
          cwf_below(bus.remaining, bus.final_set)) begin
        final_q <= 1'b1;
      end else if (final_q &&
          cwf_above(bus.remaining, bus.final_clr)) begin
        final_q <= 1'b0;
      end
    end
  end

  // one-cycle event pulses, aligned with the flag change
  always_ff @(posedge clk) begin
    if (rst) begin
      ev_q <= '0;
    end else begin
      ev_q <= '0;
      if (bus.rem_upd) begin
        ev_q[`CWF_EV_INIT_SET] <= !init_q &&
          cwf_below(bus.remaining, bus.init_set);
        ev_q[`CWF_EV_INIT_CLR] <= init_q &&
          cwf_above(bus.remaining, bus.init_clr);
        ev_q[`CWF_EV_FINAL_SET] <= !final_q &&
          bus.final_set != `CWF_FINAL_OFF &&
          cwf_below(bus.remaining, bus.final_set);
        ev_q[`CWF_EV_FINAL_CLR] <= final_q &&
          cwf_above(bus.remaining, bus.final_clr);
      end
    end
  end

  assign bus.init_flag = init_q;
  assign bus.final_flag = final_q;
  assign bus.events = ev_q;
endmodule
`default_nettype wire

// [testbench/cwf_host.sv]
// Purpose: apb host model that reads flags and capacity
// Assumes: slave may add any number of wait states
// Notes: psel and penable rest at zero between transfers, other lines keep their last values
`timescale 1ns/1ps
`default_nettype none
module cwf_host (
  // clock
  input wire logic clk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdata;
  logic err;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////
  // leading edge keeps a released strobe from being raised in one step
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/cwf_top_props.sv]
// Purpose: port level checks of the capacity warning block
// Assumes: one wait state slave, flags follow capacity updates
// Notes: bound to the top module
`timescale 1ns/1ps
`default_nettype none
module cwf_props (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // sense and warnings
  input wire logic SENSE_SAMPLE_VALID,
  input wire logic CAPACITY_INITIAL_WARNING_FLAG,
  input wire logic CAPACITY_FINAL_WARNING_FLAG,
  input wire logic IRQ
);
  logic fi_q;
  logic ff_q;
  logic chg;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  always_ff @(posedge SYS_CLK) begin
    fi_q <= CAPACITY_INITIAL_WARNING_FLAG;
    ff_q <= CAPACITY_FINAL_WARNING_FLAG;
  end
  assign chg = (fi_q != CAPACITY_INITIAL_WARNING_FLAG) ||
    (ff_q != CAPACITY_FINAL_WARNING_FLAG);

  ////////////////////////////////////////
  a_ready_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("pready late");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("pready outside access");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("pready longer than a cycle");
  a_rdata_idle: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0)
    else $error("read data outside a read answer");
  a_err_no_data: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error answer malformed");
  a_reset_clears: assert property (disable iff (1'b0) RESET |=>
    !CAPACITY_INITIAL_WARNING_FLAG && !CAPACITY_FINAL_WARNING_FLAG &&
    !IRQ && !PREADY) else $error("outputs not cleared by reset");
  // sample or load edge, capacity flop, flag flop, then seen here
  a_flag_on_update: assert property (chg |->
    $past(SENSE_SAMPLE_VALID, 2) || $past(PREADY, 2))
    else $error("flag moved without an update");
  a_irq_cause: assert property ($rose(IRQ) |->
    $past(chg) || $past(PREADY) || $past(PREADY, 2))
    else $error("irq rose without a cause");

  c_init: cover property ($rose(CAPACITY_INITIAL_WARNING_FLAG));
  c_final: cover property ($rose(CAPACITY_FINAL_WARNING_FLAG));
  c_irq: cover property ($rose(IRQ));
  c_err: cover property (PSLVERR);
endmodule

bind cwf_top cwf_props cwf_props_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SENSE_SAMPLE_VALID(SENSE_SAMPLE_VALID),
  .CAPACITY_INITIAL_WARNING_FLAG(CAPACITY_INITIAL_WARNING_FLAG),
  .CAPACITY_FINAL_WARNING_FLAG(CAPACITY_FINAL_WARNING_FLAG), .IRQ(IRQ));
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench of the capacity warning block
// Assumes: calibration at its default gain of one until t_integ writes gain three, shift one
// Notes: capacity writes count as updates, so most cases use them
`include "cwf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk, rst, sv, fi, ff, irq, psel, pen, pwr, prdy, perr;
  logic [7:0] padr;
  logic [31:0] pwd, prd;
  logic signed [15:0] pos, neg;
  int bad_count, compares;

  cwf_top cwf_top_inst (.SYS_CLK(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd),
    .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .SENSE_SAMPLE_VALID(sv), .SENSE_INPUT_POS(pos),
    .SENSE_INPUT_NEG(neg), .CAPACITY_INITIAL_WARNING_FLAG(fi),
    .CAPACITY_FINAL_WARNING_FLAG(ff), .IRQ(irq));
  cwf_host cwf_host_inst (.clk(clk), .psel(psel), .penable(pen),
    .pwrite(pwr), .paddr(padr), .pwdata(pwd), .prdata(prd),
    .pready(prdy), .pslverr(perr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cwf_host_inst.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cwf_host_inst.xfer(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), cwf_host_inst.rdata, exp);
  endtask

  // four edges cover the update, flag and irq stages
  task automatic rem(input logic [15:0] v, input logic ei, input logic ef);
    wr(`CWF_OFF_REMAIN, {16'h0, v});
    repeat (4) @(posedge clk);
    check("init flag", fi, ei);
    check("final flag", ff, ef);
  endtask

  task automatic samp(input logic [15:0] p, input logic [15:0] n);
    @(posedge clk);
    sv <= 1'b1;
    pos <= p;
    neg <= n;
    @(posedge clk);
    sv <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    rd(`CWF_OFF_INIT_SET, 32'h96);
    rd(`CWF_OFF_INIT_CLR, 32'hAF);
    rd(`CWF_OFF_FINAL_SET, 32'h4B);
    rd(`CWF_OFF_FINAL_CLR, 32'h64);
    rd(`CWF_OFF_FLAGS, 32'h0);
  endtask

  // strict compares: a value equal to a threshold moves nothing
  task automatic t_hyst;
    rem(16'h00C8, 1'b0, 1'b0);
    rem(16'h0096, 1'b0, 1'b0);
    rem(16'h0095, 1'b1, 1'b0);
    rem(16'h00AF, 1'b1, 1'b0);
    rem(16'h00B0, 1'b0, 1'b0);
    rem(16'h004B, 1'b1, 1'b0);
    rem(16'h004A, 1'b1, 1'b1);
    rem(16'h0064, 1'b1, 1'b1);
    rem(16'h0065, 1'b1, 1'b0);
    rd(`CWF_OFF_FLAGS, 32'h1);
  endtask

  task automatic t_off;
    wr(`CWF_OFF_FINAL_SET, 32'hFFFF);
    rem(16'h0000, 1'b1, 1'b0);
    wr(`CWF_OFF_FINAL_SET, 32'h4B);
    rem(16'h000A, 1'b1, 1'b1);
    rem(16'h00C8, 1'b0, 1'b0);
  endtask

  task automatic t_integ;
    wr(`CWF_OFF_CPM, 32'h4);
    wr(`CWF_OFF_CTRL, 32'h1);
    rem(16'h0096, 1'b0, 1'b0);
    samp(16'sh0, 16'sh4);
    check("init flag", fi, 1'b1);
    rd(`CWF_OFF_CURRENT, 32'hFFFF_FFFC);
    rd(`CWF_OFF_REMAIN, 32'h95);
    rem(16'h00C8, 1'b0, 1'b0);
    samp(16'sh3, 16'sh1);
    samp(16'sh3, 16'sh1);
    rd(`CWF_OFF_REMAIN, 32'hC9);
    // gain three, shift one: a diff of three gives four counts
    wr(`CWF_OFF_CAL, 32'h0001_0003);
    rd(`CWF_OFF_CAL, 32'h0001_0003);
    samp(16'sh5, 16'sh2);
    rd(`CWF_OFF_REMAIN, 32'hCA);
    wr(`CWF_OFF_CTRL, 32'h0);
    samp(16'sh0, 16'sh4);
    rd(`CWF_OFF_REMAIN, 32'hCA);
  endtask

  task automatic t_load;
    wr(`CWF_OFF_FULL, 32'h3E8);
    wr(`CWF_OFF_LOADLOSS, 32'h14);
    rd(`CWF_OFF_FULL, 32'h3E8);
    rd(`CWF_OFF_UNC_REM, 32'hDE);
    rd(`CWF_OFF_UNC_FULL, 32'h3FC);
    rem(16'hFFF0, 1'b0, 1'b0);
    rd(`CWF_OFF_UNC_REM, 32'hFFFF);
  endtask

  task automatic t_irq;
    wr(`CWF_OFF_INT_STAT, 32'hF);
    wr(`CWF_OFF_INT_MASK, 32'h1);
    rd(`CWF_OFF_INT_STAT, 32'h0);
    rem(16'h0095, 1'b1, 1'b0);
    check("irq", irq, 1'b1);
    rd(`CWF_OFF_INT_STAT, 32'h1);
    wr(`CWF_OFF_INT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check("irq", irq, 1'b0);
    wr(`CWF_OFF_INT_STAT, 32'h1);
    rd(`CWF_OFF_INT_STAT, 32'h0);
  endtask

  task automatic t_err;
    cwf_host_inst.xfer(1'b0, 8'h40, 32'h0);
    check("slverr", cwf_host_inst.err, 1'b1);
    check("err data", cwf_host_inst.rdata, 32'h0);
    wr(`CWF_OFF_FLAGS, 32'h2);
    rd(`CWF_OFF_FLAGS, 32'h1);
  endtask

  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end

  initial begin
    rst = 1'b1;
    sv = 1'b0;
    pos = 16'sh0;
    neg = 16'sh0;
    bad_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_hyst;
    t_off;
    t_integ;
    t_load;
    t_irq;
    t_err;
    report_and_stop;
  end
endmodule
`default_nettype wire
